// [src/fcc_pkg.sv]
// Package of constants for the flash command controller
`default_nettype none
package fcc_pkg;
  // Register byte addresses on the word-aligned register bus
  localparam logic [5:0] FCC_ADDR_STAT     = 6'h00;
  localparam logic [5:0] FCC_ADDR_IDX      = 6'h04;
  localparam logic [5:0] FCC_ADDR_PHI      = 6'h08;
  localparam logic [5:0] FCC_ADDR_PLO      = 6'h0c;
  localparam logic [5:0] FCC_ADDR_ECCIDX   = 6'h10;
  localparam logic [5:0] FCC_ADDR_ECCR     = 6'h14;
  localparam logic [5:0] FCC_ADDR_RSVA     = 6'h18;
  localparam logic [5:0] FCC_ADDR_RSVB     = 6'h1c;
  localparam logic [5:0] FCC_ADDR_PROT     = 6'h20;
  localparam logic [5:0] FCC_ADDR_DPROT    = 6'h24;
  localparam logic [5:0] FCC_ADDR_OPT      = 6'h28;
  localparam logic [5:0] FCC_ADDR_SEC      = 6'h2c;
  localparam logic [5:0] FCC_ADDR_MODE     = 6'h30;
  // Status register bit positions
  localparam int FCC_STAT_CCF  = 7;
  localparam int FCC_STAT_ACC  = 5;
  localparam int FCC_STAT_PV   = 4;
  localparam int FCC_STAT_MG1  = 1;
  localparam int FCC_STAT_MG0  = 0;
  // Command codes
  localparam logic [7:0] FCC_CMD_ERVSEC = 8'h03;
  localparam logic [7:0] FCC_CMD_RDONCE = 8'h04;
  localparam logic [7:0] FCC_CMD_ERBLK  = 8'h09;
  localparam logic [7:0] FCC_CMD_ERSEC  = 8'h0a;
  localparam logic [7:0] FCC_CMD_UNSEC  = 8'h0b;
  localparam logic [7:0] FCC_CMD_VKEY   = 8'h0c;
  localparam logic [7:0] FCC_CMD_UMARG  = 8'h0d;
  // Parameter indices
  localparam logic [2:0] FCC_IDX_ERVSEC = 3'h2;
  localparam logic [2:0] FCC_IDX_RDONCE = 3'h1;
  localparam logic [2:0] FCC_IDX_ERBLK  = 3'h1;
  localparam logic [2:0] FCC_IDX_ERSEC  = 3'h1;
  localparam logic [2:0] FCC_IDX_UNSEC  = 3'h0;
  localparam logic [2:0] FCC_IDX_VKEY   = 3'h4;
  localparam logic [2:0] FCC_IDX_UMARG  = 3'h1;
  localparam logic [15:0] FCC_RDONCE_MAX = 16'h0007;
  // Address space: 23-bit global address, 128 Kbyte windows, phrase = 8 bytes
  localparam logic [6:0] FCC_BLK_LO = 7'h7e;
  localparam int FCC_WIN_BITS = 17;
  // Reset values (fully protected and secured defaults)
  localparam logic [7:0] FCC_PROT_DEF = 8'h00;
  localparam logic [7:0] FCC_SEC_DEF  = 8'hff;
  localparam logic [7:0] FCC_OPT_DEF  = 8'hff;
  localparam logic [7:0] FCC_RSV_VAL  = 8'h00;
  // Timing in cycles of the respective clock (both clocks taken from CLK_I)
  localparam int FCC_SEC_OP_CYC   = 20020;
  localparam int FCC_SEC_BUS_TYP  = 700;
  localparam int FCC_SEC_BUS_MAX  = 1100;
  localparam int FCC_BLK_OP_CYC   = 100100;
  localparam int FCC_BLK_BUS_CYC  = 35000;
  localparam int FCC_VKEY_BUS_CYC = 400;
  localparam int FCC_UMARG_BUS_CYC = 350;
  localparam int FCC_INIT_HOLD_CYC = 16;
  localparam int FCC_INIT_CYC      = 64;
  localparam int FCC_VERIFY_CYC    = 8;
  typedef enum logic [1:0] {FCC_S_HOLD, FCC_S_INIT, FCC_S_IDLE, FCC_S_RUN} fcc_state_t;
endpackage
`default_nettype wire

// [src/fcc_top.sv]
// Flash command controller: reset load, command launch, checks and timing
//
// Function
// - Reset runs load of configuration and protection
// - Load error gives protected, secured defaults
// - Double fault at load sets both verify bits
// - Command complete flag clear during load
// - Bus stalled early; later reads served
// - Parameter writes dropped while load busy
// - Load end sets flag, enables commands
// - Reset aborts running command at once
// - Launch permitted by mode and security
// - Two reserved registers read zero, ignore writes
// - ECC result captures faults, field by index
// - Erase verify checks section, then sets flag
// - Access error on wrong index or mode
// - Access error on bad or misaligned address
// - Access error crossing 128K; no protect flag
// - Verify read sets any and uncorrectable bits
// - Read once returns phrase words at 2..5
// - Sector erase 20020 op plus 700/1100 bus
// - Block erase 100100 op plus 35000 bus
// - Key verify 400, margin set 350 cycles
`default_nettype none
module fcc_top
  import fcc_pkg::*;
#(
  parameter int SEC_OP_CYC = fcc_pkg::FCC_SEC_OP_CYC,
  parameter int BLK_OP_CYC = fcc_pkg::FCC_BLK_OP_CYC,
  parameter int BLK_BUS_CYC = fcc_pkg::FCC_BLK_BUS_CYC,
  parameter bit SEC_WORST = 1'b0
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RSTN_I,
  // Avalon-MM slave
  input  wire logic [5:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // Reset-time load results from the array
  input  wire logic [7:0]  LOAD_PROT_I,
  input  wire logic [7:0]  LOAD_DPROT_I,
  input  wire logic [7:0]  LOAD_OPT_I,
  input  wire logic [7:0]  LOAD_SEC_I,
  input  wire logic        LOAD_ERR_I,
  input  wire logic        LOAD_DBL_I,
  // Array read results
  input  wire logic [63:0] ARRAY_DATA_I,
  input  wire logic        ARRAY_ERR_I,
  input  wire logic        ARRAY_DBL_I,
  input  wire logic        ARRAY_SGL_I,
  input  wire logic [22:0] ARRAY_FADDR_I,
  // Operating mode: high for special mode, which allows unsecure but refuses key verify
  input  wire logic        SPECIAL_MODE_I,
  // Busy indication to the array
  output logic             CMD_BUSY_O,
  output logic      [7:0]  CMD_CODE_O
);
  import fcc_pkg::*;

  // Bus-clock time for sector erase: typical or worst case
  localparam int SEC_BUS = SEC_WORST ? FCC_SEC_BUS_MAX : FCC_SEC_BUS_TYP;

  fcc_state_t  state_q;
  logic [17:0] cnt_q;
  logic [15:0] words_q [6];
  logic [2:0]  idx_q;
  logic        ccf_q, acc_q, pv_q, mg1_q, mg0_q;
  logic [7:0]  prot_q, dprot_q, opt_q, sec_q;
  logic [7:0]  cmd_q;
  logic [17:0] run_len_q;
  logic [2:0]  eccidx_q;
  logic [22:0] eccaddr_q;
  logic [15:0] eccdat_q;
  logic        eccv_q;
  logic        rd_ack_q;
  logic [31:0] rdata_q;

  wire logic wr  = AVS_WRITE_I;
  wire logic [7:0] wb = AVS_WRITEDATA_I[7:0];
  wire logic secured = sec_q[1:0] != 2'b10;

  // Launch checks
  logic [22:0] gaddr;
  logic [23:0] gend;
  logic        launch_ok;
  logic [17:0] len;
  always_comb begin
    gaddr = {words_q[0][6:0], words_q[1]};
    gend  = {1'b0, gaddr} + {5'h00, words_q[2], 3'h0} - 24'h000001;
    launch_ok = 1'b0;
    len = 18'h00001;
    case (words_q[0][15:8])
      FCC_CMD_ERVSEC: begin
        launch_ok = idx_q == FCC_IDX_ERVSEC
          && gaddr[22:16] >= FCC_BLK_LO && gaddr[2:0] == 3'h0
          && words_q[2] != 16'h0000
          && gend[23:FCC_WIN_BITS] == {1'b0, gaddr[22:FCC_WIN_BITS]};
        len = 18'(FCC_VERIFY_CYC) + 18'(words_q[2]);
      end
      FCC_CMD_RDONCE: begin
        launch_ok = idx_q == FCC_IDX_RDONCE && words_q[1] <= FCC_RDONCE_MAX;
        len = 18'(FCC_VERIFY_CYC);
      end
      FCC_CMD_ERSEC: begin
        launch_ok = idx_q == FCC_IDX_ERSEC && !secured && gaddr[22:16] >= FCC_BLK_LO;
        len = 18'(SEC_OP_CYC + SEC_BUS);
      end
      FCC_CMD_ERBLK: begin
        launch_ok = idx_q == FCC_IDX_ERBLK && !secured && gaddr[22:16] >= FCC_BLK_LO;
        len = 18'(BLK_OP_CYC + BLK_BUS_CYC);
      end
      FCC_CMD_UNSEC: begin
        launch_ok = idx_q == FCC_IDX_UNSEC && SPECIAL_MODE_I;
        len = 18'(BLK_OP_CYC + BLK_BUS_CYC);
      end
      FCC_CMD_VKEY: begin
        launch_ok = idx_q == FCC_IDX_VKEY && secured && !SPECIAL_MODE_I;
        len = 18'(FCC_VKEY_BUS_CYC);
      end
      FCC_CMD_UMARG: begin
        launch_ok = idx_q == FCC_IDX_UMARG;
        len = 18'(FCC_UMARG_BUS_CYC);
      end
      default: launch_ok = 1'b0;
    endcase
  end

  wire logic stat_wr  = wr && AVS_ADDRESS_I == FCC_ADDR_STAT && state_q == FCC_S_IDLE;
  wire logic launch   = stat_wr && wb[FCC_STAT_CCF] && ccf_q && !acc_q && !pv_q;
  wire logic run_done = state_q == FCC_S_RUN && cnt_q == run_len_q;
  // Parameter writes only while idle: not during load or a running command
  wire logic prm_open = state_q == FCC_S_IDLE;

  // Sequencer; synchronous reset drops any running command at once
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      state_q   <= FCC_S_HOLD;
      cnt_q     <= '0;
      run_len_q <= '0;
      cmd_q     <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 18'h00001;
      case (state_q)
        FCC_S_HOLD: if (cnt_q == 18'(FCC_INIT_HOLD_CYC)) state_q <= FCC_S_INIT;
        FCC_S_INIT: if (cnt_q == 18'(FCC_INIT_CYC)) state_q <= FCC_S_IDLE;
        FCC_S_IDLE: begin
          cnt_q <= '0;
          if (launch && launch_ok) begin
            state_q   <= FCC_S_RUN;
            run_len_q <= len;
            cmd_q     <= words_q[0][15:8];
          end
        end
        FCC_S_RUN: if (run_done) state_q <= FCC_S_IDLE;
        default: state_q <= FCC_S_HOLD;
      endcase
    end
  end

  // Status flags; hardware sets beat software clears
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ccf_q <= 1'b0;
      acc_q <= 1'b0;
      pv_q  <= 1'b0;
      mg1_q <= 1'b0;
      mg0_q <= 1'b0;
    end else begin
      if (state_q == FCC_S_INIT && cnt_q == 18'(FCC_INIT_CYC)) begin
        ccf_q <= 1'b1;
        if (LOAD_DBL_I) begin
          mg1_q <= 1'b1;
          mg0_q <= 1'b1;
        end
      end
      if (stat_wr && wb[FCC_STAT_ACC]) acc_q <= 1'b0;
      if (stat_wr && wb[FCC_STAT_PV]) pv_q <= 1'b0;
      if (launch) begin
        mg1_q <= 1'b0;
        mg0_q <= 1'b0;
        if (launch_ok) ccf_q <= 1'b0;
        else acc_q <= 1'b1;
      end
      if (state_q == FCC_S_RUN) begin
        if (cmd_q == FCC_CMD_ERVSEC && ARRAY_ERR_I) mg1_q <= 1'b1;
        if (cmd_q == FCC_CMD_ERVSEC && ARRAY_DBL_I) mg0_q <= 1'b1;
        if (run_done) ccf_q <= 1'b1;
      end
    end
  end

  // Configuration loaded at reset, falling back to defaults on error
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      prot_q  <= FCC_PROT_DEF;
      dprot_q <= FCC_PROT_DEF;
      opt_q   <= FCC_OPT_DEF;
      sec_q   <= FCC_SEC_DEF;
    end else if (state_q == FCC_S_INIT && cnt_q == 18'(FCC_INIT_CYC)) begin
      prot_q  <= LOAD_ERR_I ? FCC_PROT_DEF : LOAD_PROT_I;
      dprot_q <= LOAD_ERR_I ? FCC_PROT_DEF : LOAD_DPROT_I;
      opt_q   <= LOAD_ERR_I ? FCC_OPT_DEF : LOAD_OPT_I;
      sec_q   <= LOAD_ERR_I ? FCC_SEC_DEF : LOAD_SEC_I;
    end
  end

  // Parameter index and words
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      idx_q <= 3'h0;
      for (int i = 0; i < 6; i++) words_q[i] <= 16'h0000;
    end else begin
      if (wr && prm_open && AVS_ADDRESS_I == FCC_ADDR_IDX) idx_q <= wb[2:0];
      if (wr && prm_open && AVS_ADDRESS_I == FCC_ADDR_PHI && idx_q < 3'h6) words_q[idx_q][15:8] <= wb;
      if (wr && prm_open && AVS_ADDRESS_I == FCC_ADDR_PLO && idx_q < 3'h6) words_q[idx_q][7:0] <= wb;
      // Read once returns four words at indices 2..5
      if (run_done && cmd_q == FCC_CMD_RDONCE) begin
        words_q[2] <= ARRAY_DATA_I[63:48];
        words_q[3] <= ARRAY_DATA_I[47:32];
        words_q[4] <= ARRAY_DATA_I[31:16];
        words_q[5] <= ARRAY_DATA_I[15:0];
      end
    end
  end

  // ECC capture: first fault is kept until software writes the index
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      eccidx_q  <= 3'h0;
      eccaddr_q <= '0;
      eccdat_q  <= 16'h0000;
      eccv_q    <= 1'b0;
    end else begin
      if (wr && AVS_ADDRESS_I == FCC_ADDR_ECCIDX) begin
        eccidx_q <= wb[2:0];
        eccv_q   <= 1'b0;
      end
      if (!eccv_q && (ARRAY_SGL_I || ARRAY_DBL_I)) begin
        eccv_q    <= 1'b1;
        eccaddr_q <= ARRAY_FADDR_I;
        eccdat_q  <= ARRAY_DATA_I[15:0];
      end
    end
  end

  // Read mux
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h00000000;
    case (AVS_ADDRESS_I)
      FCC_ADDR_STAT: rmux = {24'h000000, ccf_q, 1'b0, acc_q, pv_q, 2'b00, mg1_q, mg0_q};
      FCC_ADDR_IDX:  rmux = {29'h00000000, idx_q};
      FCC_ADDR_PHI:  rmux = {24'h000000, idx_q < 3'h6 ? words_q[idx_q][15:8] : 8'h00};
      FCC_ADDR_PLO:  rmux = {24'h000000, idx_q < 3'h6 ? words_q[idx_q][7:0] : 8'h00};
      FCC_ADDR_ECCIDX: rmux = {29'h00000000, eccidx_q};
      FCC_ADDR_ECCR: begin
        case (eccidx_q)
          3'h0: rmux = {16'h0000, eccv_q, 8'h00, eccaddr_q[22:16]};
          3'h1: rmux = {16'h0000, eccaddr_q[15:0]};
          3'h2: rmux = {16'h0000, eccdat_q};
          default: rmux = 32'h00000000;
        endcase
      end
      FCC_ADDR_RSVA, FCC_ADDR_RSVB: rmux = {24'h000000, FCC_RSV_VAL};
      FCC_ADDR_PROT:  rmux = {24'h000000, prot_q};
      FCC_ADDR_DPROT: rmux = {24'h000000, dprot_q};
      FCC_ADDR_OPT:   rmux = {24'h000000, opt_q};
      FCC_ADDR_SEC:   rmux = {24'h000000, sec_q};
      FCC_ADDR_MODE:  rmux = {30'h00000000, secured, SPECIAL_MODE_I};
      default: rmux = 32'h00000000;
    endcase
  end

  // Bus answer: reads take one extra cycle; all access stalled in hold
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      rd_ack_q <= 1'b0;
      rdata_q  <= 32'h00000000;
    end else begin
      rd_ack_q <= AVS_READ_I && !rd_ack_q && state_q != FCC_S_HOLD;
      if (AVS_READ_I && !rd_ack_q) rdata_q <= rmux;
    end
  end

  always_comb begin
    AVS_READDATA_O    = rdata_q;
    AVS_WAITREQUEST_O = state_q == FCC_S_HOLD || (AVS_READ_I && !rd_ack_q);
  end

  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      CMD_BUSY_O <= 1'b0;
      CMD_CODE_O <= 8'h00;
    end else begin
      CMD_BUSY_O <= state_q == FCC_S_RUN && !run_done;
      CMD_CODE_O <= cmd_q;
    end
  end
endmodule
`default_nettype wire

// [testbench/fcc_array_model.sv]
// Model of the flash array behind the controller
`default_nettype none
module fcc_array_model #(
  parameter logic [7:0]  P_PROT = 8'h5a,
  parameter logic [7:0]  P_SEC  = 8'hfe,
  parameter logic [63:0] P_DATA = 64'h0
) (
  // Fault controls from the bench
  input  wire logic        load_err_i,
  input  wire logic        load_dbl_i,
  input  wire logic        vfy_err_i,
  // Controller side
  output logic      [7:0]  prot_o,
  output logic      [7:0]  dprot_o,
  output logic      [7:0]  opt_o,
  output logic      [7:0]  sec_o,
  output logic             lerr_o,
  output logic             ldbl_o,
  output logic      [63:0] data_o,
  output logic             aerr_o,
  output logic             adbl_o,
  output logic             asgl_o,
  output logic      [22:0] faddr_o
);
  timeunit 1ns;
  timeprecision 1ns;
  assign prot_o  = P_PROT;
  assign dprot_o = 8'h3c;
  assign opt_o   = 8'h81;
  assign sec_o   = P_SEC;
  assign lerr_o  = load_err_i;
  assign ldbl_o  = load_dbl_i;
  assign data_o  = P_DATA;
  // A single fault never comes alone, so the any-error line follows it too; double fault stays low
  assign aerr_o  = vfy_err_i;
  assign adbl_o  = 1'b0;
  assign asgl_o  = vfy_err_i;
  assign faddr_o = 23'h7e0010;
endmodule
`default_nettype wire

// [testbench/fcc_props.sv]
// Port checker of the flash command controller
`default_nettype none
module fcc_props
  import fcc_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  // Register bus
  input wire logic [5:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O,
  // Command state
  input wire logic        CMD_BUSY_O,
  input wire logic [7:0]  CMD_CODE_O
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] up_q;
  logic       rd_ok;
  logic       st_rd;
  // Saturates so that long runs never wrap back into the load window
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) up_q <= 8'h00;
    else if (up_q != 8'hff) up_q <= up_q + 8'h01;
  end
  assign rd_ok = AVS_READ_I && !AVS_WAITREQUEST_O;
  assign st_rd = rd_ok && AVS_ADDRESS_I == FCC_ADDR_STAT;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  stall_hold_a: assert property (!$past(RSTN_I) |-> AVS_WAITREQUEST_O [*8])
    else $error("bus not stalled after reset");
  write_free_a: assert property (up_q > 8'd20 && AVS_WRITE_I |-> !AVS_WAITREQUEST_O)
    else $error("write stalled after hold");
  init_flag_a: assert property (st_rd && up_q < 8'd66 |-> !AVS_READDATA_O[7])
    else $error("complete flag set during load");
  // Read data is captured a cycle early, so the cycle after busy falls is excluded
  ready_flag_a: assert property (st_rd && up_q > 8'd95 && !CMD_BUSY_O && !$past(CMD_BUSY_O) |-> AVS_READDATA_O[7])
    else $error("complete flag clear when idle");
  busy_flag_a: assert property (st_rd && CMD_BUSY_O |-> !AVS_READDATA_O[7])
    else $error("complete flag set while busy");
  rsv_zero_a: assert property (rd_ok && AVS_ADDRESS_I[5:3] == 3'h3 |-> AVS_READDATA_O == 32'h0)
    else $error("reserved register not zero");
  key_time_a: assert property ($rose(CMD_BUSY_O) && CMD_CODE_O == FCC_CMD_VKEY |-> ##[1:400] !CMD_BUSY_O)
    else $error("key check too long");
  margin_time_a: assert property ($rose(CMD_BUSY_O) && CMD_CODE_O == FCC_CMD_UMARG |-> ##[1:350] !CMD_BUSY_O)
    else $error("margin set too long");
  reset_abort_a: assert property ($rose(RSTN_I) |-> !CMD_BUSY_O)
    else $error("command survived reset");
  cover property (st_rd && CMD_BUSY_O);
  cover property ($fell(CMD_BUSY_O) && CMD_CODE_O == FCC_CMD_ERVSEC);
  cover property ($rose(CMD_BUSY_O) && CMD_CODE_O == FCC_CMD_ERSEC);
endmodule
bind fcc_top fcc_props u_props (.CLK_I, .RSTN_I, .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I,
  .AVS_READDATA_O, .AVS_WAITREQUEST_O, .CMD_BUSY_O, .CMD_CODE_O);
`default_nettype wire

// [testbench/tb_flash_command_controller.sv]
// Self-checking bench of the flash command controller
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin errors++; \
  $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_flash_command_controller;
  import fcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [63:0] P_DATA = 64'h1111_2222_3333_4444;
  logic clk = 1'b0, rst_n = 1'b0, rd_en = 1'b0, wr_en = 1'b0, mode = 1'b1;
  logic load_err = 1'b0, load_dbl = 1'b0, vfy_err = 1'b0, waitreq, busy;
  logic m_lerr, m_ldbl, m_aerr, m_adbl, m_asgl;
  logic [5:0] addr = 6'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [7:0] code, m_prot, m_dprot, m_opt, m_sec;
  logic [63:0] m_data;
  logic [22:0] m_faddr;
  int errors = 0, check_count = 0, cyc = 0;
  fcc_array_model #(.P_PROT(8'h5a), .P_SEC(8'hfe), .P_DATA(P_DATA)) u_array (.load_err_i(load_err),
    .load_dbl_i(load_dbl), .vfy_err_i(vfy_err), .prot_o(m_prot), .dprot_o(m_dprot), .opt_o(m_opt),
    .sec_o(m_sec), .lerr_o(m_lerr), .ldbl_o(m_ldbl), .data_o(m_data), .aerr_o(m_aerr),
    .adbl_o(m_adbl), .asgl_o(m_asgl), .faddr_o(m_faddr));
  // Shortened erase counts keep the abort case quick
  fcc_top #(.SEC_OP_CYC(10), .BLK_OP_CYC(10), .BLK_BUS_CYC(10)) dut (.CLK_I(clk), .RSTN_I(rst_n),
    .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata),
    .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .LOAD_PROT_I(m_prot), .LOAD_DPROT_I(m_dprot),
    .LOAD_OPT_I(m_opt), .LOAD_SEC_I(m_sec), .LOAD_ERR_I(m_lerr), .LOAD_DBL_I(m_ldbl),
    .ARRAY_DATA_I(m_data), .ARRAY_ERR_I(m_aerr), .ARRAY_DBL_I(m_adbl), .ARRAY_SGL_I(m_asgl),
    .ARRAY_FADDR_I(m_faddr), .SPECIAL_MODE_I(mode), .CMD_BUSY_O(busy), .CMD_CODE_O(code));
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude;
    end
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= {24'h0, d};
    wr_en <= 1'b1;
    do @(posedge clk); while (waitreq !== 1'b0);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    do @(posedge clk); while (waitreq !== 1'b0);
    d = rdata[7:0];
    rd_en <= 1'b0;
  endtask
  task automatic wait_ready(output logic [7:0] st);
    do rd(FCC_ADDR_STAT, st); while (st[7] !== 1'b1);
  endtask
  task automatic word(input logic [2:0] i, input logic [15:0] w);
    wr(FCC_ADDR_IDX, {5'h0, i});
    wr(FCC_ADDR_PHI, w[15:8]);
    wr(FCC_ADDR_PLO, w[7:0]);
  endtask
  task automatic launch(input logic [15:0] w0, w1, w2, input logic [2:0] last);
    word(3'h0, w0);
    word(3'h1, w1);
    word(3'h2, w2);
    wr(FCC_ADDR_IDX, {5'h0, last});
    wr(FCC_ADDR_STAT, 8'h80);
  endtask
  task automatic t_init;
    logic [7:0] d;
    rd(FCC_ADDR_STAT, d);
    `CHK("flag in load", 1'b0, d[7])
    wr(FCC_ADDR_IDX, 8'h05);
    wait_ready(d);
    rd(FCC_ADDR_IDX, d);
    `CHK("index in load", 3'h0, d[2:0])
    rd(FCC_ADDR_PROT, d);
    `CHK("prot", 8'h5a, d)
    rd(FCC_ADDR_SEC, d);
    `CHK("sec", 8'hfe, d)
    wr(FCC_ADDR_RSVA, 8'hff);
    wr(FCC_ADDR_RSVB, 8'hff);
    rd(FCC_ADDR_RSVA, d);
    `CHK("rsv a", 8'h00, d)
    rd(FCC_ADDR_RSVB, d);
    `CHK("rsv b", 8'h00, d)
    rd(6'h3c, d);
  endtask
  task automatic t_erv;
    logic [15:0] w0 [4] = '{16'h037e, 16'h0310, 16'h037f, 16'h037e};
    logic [15:0] w1 [4] = '{16'h0003, 16'h0000, 16'hfff8, 16'h0000};
    logic [15:0] w2 [4] = '{16'h0004, 16'h0004, 16'h0002, 16'h0004};
    logic [2:0]  ix [4] = '{3'h2, 3'h2, 3'h2, 3'h1};
    logic [7:0]  st;
    launch(16'h037e, 16'h0000, 16'h0004, 3'h2);
    wait_ready(st);
    `CHK("verify clean", 8'h80, st & 8'hb3)
    vfy_err <= 1'b1;
    launch(16'h037e, 16'h0000, 16'h0004, 3'h2);
    wait_ready(st);
    `CHK("verify fault", 2'b10, st[1:0])
    vfy_err <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      launch(w0[i], w1[i], w2[i], ix[i]);
      wait_ready(st);
      `CHK("verify refused", 2'b10, st[5:4])
      wr(FCC_ADDR_STAT, 8'h30);
    end
  endtask
  task automatic t_cmds;
    logic [7:0] hi, lo;
    // Read once is issued from bench code, never from the block holding the field
    launch(16'h0400, 16'h0003, 16'h0000, 3'h1);
    wait_ready(hi);
    for (int i = 2; i < 6; i++) begin
      wr(FCC_ADDR_IDX, 8'(i));
      rd(FCC_ADDR_PHI, hi);
      rd(FCC_ADDR_PLO, lo);
      `CHK("once word", P_DATA[16*(5-i) +: 16], {hi, lo})
    end
    // Unsecured part: key verify is not available and is refused
    launch(16'h0c00, 16'h0000, 16'h0000, 3'h4);
    wait_ready(hi);
    `CHK("key refused", 2'b10, hi[5:4])
    wr(FCC_ADDR_STAT, 8'h30);
    launch(16'h0d00, 16'h0000, 16'h0000, 3'h1);
    wait_ready(hi);
    `CHK("margin code", FCC_CMD_UMARG, code)
  endtask
  task automatic t_abort;
    logic [7:0] st;
    launch(16'h0a7e, 16'h0000, 16'h0000, 3'h1);
    wr(FCC_ADDR_IDX, 8'h03);
    rd(FCC_ADDR_IDX, st);
    `CHK("index held", 3'h1, st[2:0])
    `CHK("busy", 1'b1, busy)
    load_err <= 1'b1;
    load_dbl <= 1'b1;
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    `CHK("aborted", 1'b0, busy)
    rst_n <= 1'b1;
    wait_ready(st);
    `CHK("both verify bits", 2'b11, st[1:0])
    rd(FCC_ADDR_SEC, st);
    `CHK("secure default", FCC_SEC_DEF, st)
    rd(FCC_ADDR_PROT, st);
    `CHK("protect default", FCC_PROT_DEF, st)
    // Secured defaults in normal mode allow the key verify
    mode <= 1'b0;
    launch(16'h0c00, 16'h0000, 16'h0000, 3'h4);
    wait_ready(st);
    `CHK("key status", 2'b00, st[5:4])
    `CHK("key code", FCC_CMD_VKEY, code)
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_init;
    t_erv;
    t_cmds;
    t_abort;
    conclude;
  end
endmodule
`default_nettype wire
